// >>> recorder_pkg.sv
/*
  Shared constants for the recorder nibble port: command codes, status bits,
  busy and wait times with their cycle counts, output routing codes.
  Assumes a single 250 MHz clock shared by both ends of the port.
*/
package recorder_pkg;
  localparam int NIB_W = 4;
  localparam int ADDR_NIBBLES = 10;
  localparam int ADDR_W = NIB_W * ADDR_NIBBLES;
  localparam int ARG_W = 8;
  localparam int CNT_W = 17;
  localparam int CLOCK_PERIOD_NS = 4;

  // Command codes on the data nibble
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_PAUSE = 4'h1;
  localparam logic [3:0] CMD_PLAY = 4'h2;
  localparam logic [3:0] CMD_RECORD = 4'h3;
  localparam logic [3:0] CMD_START = 4'h4;
  localparam logic [3:0] CMD_STOP = 4'h5;
  localparam logic [3:0] CMD_SET_POINTER = 4'h6;
  localparam logic [3:0] CMD_GET_POINTER = 4'h7;
  localparam logic [3:0] CMD_PHRASE_SELECT = 4'h8;
  localparam logic [3:0] CMD_LENGTH_SET = 4'h9;
  localparam logic [3:0] CMD_OUTPUT_GAIN = 4'hA;
  localparam logic [3:0] CMD_HOST_STREAM = 4'hB;

  // Status nibble layout
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_RUN_BIT = 1;
  localparam int STATUS_STREAM_BIT = 2;
  localparam logic [3:0] GAIN_RESET = 4'h0;

  // Longest busy times round down, least waits round up
  localparam int BUSY_CMD_NS = 16000;
  localparam int BUSY_CMD_CYCLES = BUSY_CMD_NS / CLOCK_PERIOD_NS;
  localparam int SET_POINTER_BUSY_NS = 270000;
  localparam int SET_POINTER_BUSY_CYCLES = SET_POINTER_BUSY_NS / CLOCK_PERIOD_NS;
  localparam int ADDR_BUSY_NS = 50000;
  localparam int ADDR_BUSY_CYCLES = ADDR_BUSY_NS / CLOCK_PERIOD_NS;
  localparam int GET_POINTER_WAIT_NS = 270000;
  localparam int GET_POINTER_WAIT_CYCLES =
    (GET_POINTER_WAIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int NIBBLE_WAIT_NS = 50000;
  localparam int NIBBLE_WAIT_CYCLES = (NIBBLE_WAIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int STOP_WINDOW_NS = 100000;
  localparam int STOP_WINDOW_CYCLES = STOP_WINDOW_NS / CLOCK_PERIOD_NS;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int TICK_HIGH_NS = 31000;
  localparam int TICK_HIGH_CYCLES = TICK_HIGH_NS / CLOCK_PERIOD_NS;

  // Recording time sizing
  localparam int INDEX_KBITS = 64;
  localparam int TIME_SCALE = 1024;
  localparam int MEM_KBITS_DEFAULT = 32768;
  localparam int SAMPLE_HZ_DEFAULT = 8000;
  localparam int SAMPLE_BITS_DEFAULT = 4;

  typedef enum logic [1:0] {ROUTE_GND, ROUTE_SG, ROUTE_LPF} route_t;

  // Seconds of recording: 1.024 * kbits / (kHz * bits), index area removed
  function automatic int record_seconds(input int mem_kbits, input int fs_hz, input int bits);
    record_seconds = (TIME_SCALE * (mem_kbits - INDEX_KBITS)) / (fs_hz * bits);
  endfunction
endpackage

// >>> recorder_bus_if.sv
/*
  Nibble bus between the recorder and its controlling host.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
interface recorder_bus_if;
  logic wr;
  logic rd;
  logic [3:0] wdata;
  logic [3:0] rdata;
  logic busy;
  logic tick;

  modport dev (input wr, input rd, input wdata, output rdata, output busy, output tick);
  modport host (output wr, output rd, output wdata, input rdata, input busy, input tick);
endinterface

// >>> recorder_device.sv
/*
  Recorder end of the nibble port: command decoder, busy timing, pointer
  load and readout, host-streamed sample tick and playback FIFO, routing.
  Assumes the host shares i_clock and keeps the busy handshake.
*/
// Contract
// - Host checks busy clear before set-pointer
// - Set-pointer address is ten nibbles, paced
// - Host may pace by fixed busy intervals
// - Busy ends by 270us, 50us per nibble
// - Host checks busy clear before get-pointer
// - Get-pointer returns ten address nibbles on reads
// - Readout reads carry data; pace by pin
// - Host waits 270us, then 50us per nibble
// - Single-nibble commands get one short busy
// - Single-nibble busy at most 16us
// - Phrase and length commands are three nibbles
// - Gain command sets level, starts transition
// - Host reads sample soon after tick rise
// - Host stops while tick high after access
// - Stop within 100us of tick rise
// - Host supplies every playback sample, no gaps; host misses the tick that rises during the start command's busy
// - Record time 1.024 kbits over kHz times bits
// - Subtract 64K index area from memory
// - Probe follows input amp recording, converter playing
// - Outputs routed by power, record, play state
`timescale 1ns/100ps
module recorder_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [PTR_W:0] count, next_count;
  logic push, pop;

  // Handshakes and pointer arithmetic
  always_comb
  begin
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    next_wr_ptr = push ? ((wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
    if (push)
      mem[wr_ptr] <= i_data;
  end

  assign o_ready = count != (PTR_W+1)'(DEPTH);
  assign o_valid = count != '0;
  assign o_data = mem[rd_ptr];
endmodule

module recorder_device
  import recorder_pkg::*;
#(
  parameter int SET_POINTER_BUSY = SET_POINTER_BUSY_CYCLES,
  parameter int ADDR_BUSY = ADDR_BUSY_CYCLES,
  parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYCLES,
  parameter int TICK_HIGH = TICK_HIGH_CYCLES,
  parameter int MEM_KBITS = MEM_KBITS_DEFAULT,
  parameter int SAMPLE_HZ = SAMPLE_HZ_DEFAULT,
  parameter int SAMPLE_BITS = SAMPLE_BITS_DEFAULT,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Nibble bus
  recorder_bus_if.dev bus,
  // Analog control
  input wire logic i_power_down,
  output logic o_probe_dac,
  output route_t o_feed_route,
  output route_t o_speaker_route,
  // Samples
  input wire logic [3:0] i_rec_sample,
  output logic o_play_valid,
  output logic [3:0] o_play_data,
  input wire logic i_play_ready,
  // Settings and state
  output logic [3:0] o_gain,
  output logic o_gain_start,
  output logic [ARG_W-1:0] o_phrase,
  output logic [ARG_W-1:0] o_length,
  output logic [ADDR_W-1:0] o_pointer,
  output logic o_recording,
  output logic o_playing,
  output logic [31:0] o_record_seconds
);
  typedef enum logic [1:0] {ST_READY, ST_ADDR_IN, ST_ADDR_OUT, ST_ARGS} state_t;
  typedef enum logic [1:0] {RUN_STOP, RUN_REC, RUN_PLAY} run_t;

  state_t state, next_state;
  run_t run, next_run;
  logic [CNT_W-1:0] busy_count, next_busy_count;
  logic [3:0] nib_left, next_nib_left;
  logic [3:0] arg_cmd, next_arg_cmd;
  logic [ADDR_W-1:0] shift, next_shift, pointer, next_pointer;
  logic [ARG_W-1:0] arg, next_arg, phrase, next_phrase, length, next_length;
  logic [3:0] gain, next_gain, rdata, next_rdata, rec_hold, next_rec_hold;
  logic gain_start, next_gain_start;
  logic dir_rec, next_dir_rec, stream_armed, next_stream_armed, paused, next_paused;
  logic got_data, next_got_data, tick, next_tick;
  logic [CNT_W-1:0] tick_count, next_tick_count;
  logic busy, streaming, fifo_ready, fifo_push;
  logic [3:0] status;

  // Backed-up FIFO holds the host off through the same busy signal
  assign busy = (busy_count != '0) || !fifo_ready;
  assign streaming = (run != RUN_STOP) && stream_armed;
  assign status = {1'b0, streaming, run != RUN_STOP, busy};

  // Command decode, nibble sequencing and busy timing
  always_comb
  begin
    next_state = state;
    next_run = run;
    next_busy_count = (busy_count != '0) ? busy_count - 1'b1 : '0;
    next_nib_left = nib_left;
    next_arg_cmd = arg_cmd;
    next_shift = shift;
    next_pointer = pointer;
    next_arg = arg;
    next_phrase = phrase;
    next_length = length;
    next_gain = gain;
    next_gain_start = 1'b0;
    next_rdata = rdata;
    next_dir_rec = dir_rec;
    next_stream_armed = stream_armed;
    next_paused = paused;
    next_got_data = got_data;
    fifo_push = 1'b0;
    // Write strobes while busy are ignored; the host owns the pacing
    if (bus.wr && !busy)
    begin
      case (state)
        ST_READY:
        begin
          if (streaming && !dir_rec && tick && !got_data)
          begin
            // First write of a tick is the playback sample
            fifo_push = 1'b1;
            next_got_data = 1'b1;
            next_busy_count = CNT_W'(BUSY_CMD_CYCLES);
          end
          else
          begin
            next_busy_count = CNT_W'(BUSY_CMD_CYCLES);
            case (bus.wdata)
              CMD_PAUSE: next_paused = 1'b1;
              CMD_PLAY: next_dir_rec = 1'b0;
              CMD_RECORD: next_dir_rec = 1'b1;
              CMD_HOST_STREAM: next_stream_armed = 1'b1;
              CMD_START:
              begin
                next_paused = 1'b0;
                if (run == RUN_STOP)
                  next_run = dir_rec ? RUN_REC : RUN_PLAY;
              end
              CMD_STOP:
              begin
                next_run = RUN_STOP;
                next_stream_armed = 1'b0;
                next_paused = 1'b0;
              end
              CMD_SET_POINTER:
              begin
                next_busy_count = CNT_W'(SET_POINTER_BUSY);
                next_nib_left = 4'(ADDR_NIBBLES);
                next_state = ST_ADDR_IN;
              end
              CMD_GET_POINTER:
              begin
                next_busy_count = CNT_W'(SET_POINTER_BUSY);
                next_shift = pointer;
                next_nib_left = 4'(ADDR_NIBBLES);
                next_state = ST_ADDR_OUT;
              end
              CMD_PHRASE_SELECT, CMD_LENGTH_SET, CMD_OUTPUT_GAIN:
              begin
                next_arg_cmd = bus.wdata;
                next_nib_left = (bus.wdata == CMD_OUTPUT_GAIN) ? 4'h1 : 4'h2;
                next_state = ST_ARGS;
              end
              default: ;
            endcase
          end
        end
        ST_ADDR_IN:
        begin
          // Low nibble first; one nibble per strobe
          next_shift = {bus.wdata, shift[ADDR_W-1:NIB_W]};
          next_nib_left = nib_left - 1'b1;
          next_busy_count = CNT_W'(ADDR_BUSY);
          if (nib_left == 4'h1)
          begin
            next_pointer = {bus.wdata, shift[ADDR_W-1:NIB_W]};
            next_state = ST_READY;
          end
        end
        ST_ARGS:
        begin
          next_arg = {arg[NIB_W-1:0], bus.wdata};
          next_nib_left = nib_left - 1'b1;
          next_busy_count = CNT_W'(BUSY_CMD_CYCLES);
          if (nib_left == 4'h1)
          begin
            next_state = ST_READY;
            if (arg_cmd == CMD_PHRASE_SELECT)
              next_phrase = {arg[NIB_W-1:0], bus.wdata};
            else if (arg_cmd == CMD_LENGTH_SET)
              next_length = {arg[NIB_W-1:0], bus.wdata};
            else
            begin
              next_gain = bus.wdata;
              next_gain_start = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // Reads: address nibbles during readout, the held record sample on a streamed recording tick, status otherwise
    if (bus.rd)
    begin
      if (state == ST_ADDR_OUT)
      begin
        if (!busy)
        begin
          next_rdata = shift[NIB_W-1:0];
          next_shift = {4'h0, shift[ADDR_W-1:NIB_W]};
          next_nib_left = nib_left - 1'b1;
          next_busy_count = CNT_W'(ADDR_BUSY);
          if (nib_left == 4'h1)
            next_state = ST_READY;
        end
      end
      else if (streaming && dir_rec && tick)
        next_rdata = rec_hold;
      else
        next_rdata = status;
    end
    // The first cycle of each sample period, at the tick rise, opens a fresh data slot; a push that cycle wins
    if (tick_count == '0 && !fifo_push)
      next_got_data = 1'b0;
  end

  // Per-sample tick while a host-streamed transfer runs
  always_comb
  begin
    next_tick_count = tick_count;
    next_rec_hold = rec_hold;
    if (!streaming)
      next_tick_count = '0;
    else if (!paused)
      next_tick_count = (tick_count == CNT_W'(SAMPLE_PERIOD - 1)) ? '0 : tick_count + 1'b1;
    if (streaming && !paused && tick_count == '0)
      next_rec_hold = i_rec_sample;
    next_tick = streaming && !paused && (next_tick_count < CNT_W'(TICK_HIGH));
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state <= ST_READY;
      run <= RUN_STOP;
      busy_count <= '0;
      nib_left <= '0;
      arg_cmd <= CMD_IDLE;
      shift <= '0;
      pointer <= '0;
      arg <= '0;
      phrase <= '0;
      length <= '0;
      gain <= GAIN_RESET;
      gain_start <= 1'b0;
      rdata <= '0;
      dir_rec <= 1'b0;
      stream_armed <= 1'b0;
      paused <= 1'b0;
      got_data <= 1'b0;
      tick <= 1'b0;
      tick_count <= '0;
      rec_hold <= '0;
    end
    else
    begin
      state <= next_state;
      run <= next_run;
      busy_count <= next_busy_count;
      nib_left <= next_nib_left;
      arg_cmd <= next_arg_cmd;
      shift <= next_shift;
      pointer <= next_pointer;
      arg <= next_arg;
      phrase <= next_phrase;
      length <= next_length;
      gain <= next_gain;
      gain_start <= next_gain_start;
      rdata <= next_rdata;
      dir_rec <= next_dir_rec;
      stream_armed <= next_stream_armed;
      paused <= next_paused;
      got_data <= next_got_data;
      tick <= next_tick;
      tick_count <= next_tick_count;
      rec_hold <= next_rec_hold;
    end
  end

  // Playback samples wait here until the decoder takes them
  recorder_fifo #(
    .WIDTH(NIB_W),
    .DEPTH(FIFO_DEPTH)
  ) play_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_valid(fifo_push),
    .i_data(bus.wdata),
    .o_ready(fifo_ready),
    .o_valid(o_play_valid),
    .o_data(o_play_data),
    .i_ready(i_play_ready)
  );

  // Bus and user-side outputs
  assign bus.rdata = rdata;
  assign bus.busy = busy;
  assign bus.tick = tick;
  assign o_probe_dac = run == RUN_PLAY;
  assign o_feed_route = i_power_down ? ROUTE_GND : ROUTE_LPF;
  assign o_speaker_route = i_power_down ? ROUTE_GND :
    (run == RUN_REC) ? ROUTE_SG : ROUTE_LPF;
  assign o_gain = gain;
  assign o_gain_start = gain_start;
  assign o_phrase = phrase;
  assign o_length = length;
  assign o_pointer = pointer;
  assign o_recording = run == RUN_REC;
  assign o_playing = run == RUN_PLAY;
  // Capacity is fixed by the memory fitted, so it is a constant
  assign o_record_seconds = 32'(record_seconds(MEM_KBITS, SAMPLE_HZ, SAMPLE_BITS));
endmodule

// >>> recorder_host.sv
/*
  Controlling end of the nibble port: polls status before pointer commands,
  sends multi-nibble commands under the busy pin, reads the pointer back,
  and streams samples on the per-sample tick.
  Assumes the recorder shares i_clock and drives busy the cycle after a strobe.
*/
`timescale 1ns/100ps
module recorder_host
  import recorder_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Nibble bus
  recorder_bus_if.host bus,
  // Command requests
  input wire logic i_cmd_valid,
  input wire logic [3:0] i_cmd,
  input wire logic [ADDR_W-1:0] i_arg,
  output logic o_cmd_ready,
  // Pointer readback
  output logic [ADDR_W-1:0] o_pointer,
  output logic o_pointer_valid,
  // Streamed samples
  input wire logic i_play_valid,
  input wire logic [3:0] i_play_data,
  output logic o_play_ready,
  output logic [3:0] o_rec_data,
  output logic o_rec_valid
);
  typedef enum logic [2:0] {H_IDLE, H_POLL, H_POLL_CHECK, H_SETTLE, H_NEXT, H_READ_WAIT,
    H_READ_TAKE} hstate_t;

  hstate_t state, next_state;
  logic [3:0] cmd, next_cmd, nib_left, next_nib_left;
  logic [ADDR_W-1:0] arg, next_arg, pointer, next_pointer;
  logic wr, next_wr, rd, next_rd, pointer_valid, next_pointer_valid;
  logic [3:0] wdata, next_wdata, rec_data, next_rec_data;
  logic rec_valid, next_rec_valid;
  logic dir_rec, next_dir_rec, armed, next_armed, streaming, next_streaming;
  logic tick_prev, accessed, next_accessed, rec_read, next_rec_read;
  logic tick_rise, stop_req;

  assign tick_rise = bus.tick && !tick_prev;
  assign stop_req = i_cmd_valid && i_cmd == CMD_STOP;

  // Sequencer for commands, address nibbles and stream accesses
  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_nib_left = nib_left;
    next_arg = arg;
    next_pointer = pointer;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_wdata = wdata;
    next_pointer_valid = 1'b0;
    next_rec_data = rec_data;
    next_rec_valid = 1'b0;
    next_dir_rec = dir_rec;
    next_armed = armed;
    next_streaming = streaming;
    next_accessed = tick_rise ? 1'b0 : accessed;
    next_rec_read = 1'b0;
    o_cmd_ready = 1'b0;
    o_play_ready = 1'b0;
    case (state)
      H_IDLE:
      begin
        if (streaming && tick_rise)
        begin
          // One access per sample, right after the tick rises
          if (dir_rec)
          begin
            next_rd = 1'b1;
            next_rec_read = 1'b1;
          end
          else
          begin
            o_play_ready = 1'b1;
            next_wr = 1'b1;
            next_wdata = i_play_valid ? i_play_data : 4'h0;
          end
          next_accessed = 1'b1;
          next_state = H_SETTLE;
        end
        else if (i_cmd_valid && (!streaming || (stop_req && accessed && bus.tick)))
        begin
          o_cmd_ready = 1'b1;
          next_cmd = i_cmd;
          next_arg = i_arg;
          next_nib_left = (i_cmd == CMD_SET_POINTER || i_cmd == CMD_GET_POINTER) ?
            4'(ADDR_NIBBLES) : (i_cmd == CMD_PHRASE_SELECT || i_cmd == CMD_LENGTH_SET) ?
            4'h2 : (i_cmd == CMD_OUTPUT_GAIN) ? 4'h1 : 4'h0;
          if (i_cmd == CMD_SET_POINTER || i_cmd == CMD_GET_POINTER)
          begin
            next_rd = 1'b1;
            next_state = H_POLL;
          end
          else
          begin
            // Stop goes out in the same tick-high phase as the access
            next_wr = 1'b1;
            next_wdata = i_cmd;
            next_state = H_SETTLE;
          end
          if (i_cmd == CMD_RECORD)
            next_dir_rec = 1'b1;
          if (i_cmd == CMD_PLAY)
            next_dir_rec = 1'b0;
          if (i_cmd == CMD_HOST_STREAM)
            next_armed = 1'b1;
          if (i_cmd == CMD_START && armed)
            next_streaming = 1'b1;
          if (i_cmd == CMD_STOP)
          begin
            next_streaming = 1'b0;
            next_armed = 1'b0;
          end
        end
      end
      H_POLL:
        next_state = H_POLL_CHECK;
      H_POLL_CHECK:
      begin
        // Status is registered, so it is valid one cycle after the strobe
        if (bus.rdata[STATUS_BUSY_BIT])
        begin
          next_rd = 1'b1;
          next_state = H_POLL;
        end
        else
        begin
          next_wr = 1'b1;
          next_wdata = cmd;
          next_state = H_SETTLE;
        end
      end
      H_SETTLE:
        next_state = H_NEXT;
      H_NEXT:
      begin
        if (!bus.busy)
        begin
          if (nib_left == 4'h0)
            next_state = H_IDLE;
          else if (cmd == CMD_GET_POINTER)
          begin
            // Busy bit cannot be read here; the pin paces readout
            next_rd = 1'b1;
            next_state = H_READ_WAIT;
          end
          else
          begin
            next_wr = 1'b1;
            next_wdata = (cmd == CMD_SET_POINTER) ? arg[NIB_W-1:0] :
              (nib_left == 4'h2) ? arg[2*NIB_W-1:NIB_W] : arg[NIB_W-1:0];
            if (cmd == CMD_SET_POINTER)
              next_arg = {4'h0, arg[ADDR_W-1:NIB_W]};
            next_nib_left = nib_left - 1'b1;
            next_state = H_SETTLE;
          end
        end
      end
      // Read data is registered, so it stands one cycle after the strobe
      H_READ_WAIT:
        next_state = H_READ_TAKE;
      H_READ_TAKE:
      begin
        next_pointer = {bus.rdata, pointer[ADDR_W-1:NIB_W]};
        next_nib_left = nib_left - 1'b1;
        next_pointer_valid = nib_left == 4'h1;
        next_state = H_NEXT;
      end
      default: next_state = H_IDLE;
    endcase
    if (rec_read)
    begin
      next_rec_data = bus.rdata;
      next_rec_valid = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state <= H_IDLE;
      cmd <= CMD_IDLE;
      nib_left <= '0;
      arg <= '0;
      pointer <= '0;
      wr <= 1'b0;
      rd <= 1'b0;
      wdata <= '0;
      pointer_valid <= 1'b0;
      rec_data <= '0;
      rec_valid <= 1'b0;
      dir_rec <= 1'b0;
      armed <= 1'b0;
      streaming <= 1'b0;
      tick_prev <= 1'b0;
      accessed <= 1'b0;
      rec_read <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      nib_left <= next_nib_left;
      arg <= next_arg;
      pointer <= next_pointer;
      wr <= next_wr;
      rd <= next_rd;
      wdata <= next_wdata;
      pointer_valid <= next_pointer_valid;
      rec_data <= next_rec_data;
      rec_valid <= next_rec_valid;
      dir_rec <= next_dir_rec;
      armed <= next_armed;
      streaming <= next_streaming;
      tick_prev <= bus.tick;
      accessed <= next_accessed;
      rec_read <= next_rec_read;
    end
  end

  // Registered strobes and data
  assign bus.wr = wr;
  assign bus.rd = rd;
  assign bus.wdata = wdata;
  assign o_pointer = pointer;
  assign o_pointer_valid = pointer_valid;
  assign o_rec_data = rec_data;
  assign o_rec_valid = rec_valid;
endmodule

// >>> recorder_bus_props.sv
/* Bus checks for the recorder nibble port.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module recorder_bus_props (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Nibble bus
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] rdata,
  input wire logic busy
);
  logic [12:0] run;
  logic [12:0] next_run;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Busy run length; a counter, since 4000 cycles is too long to unroll
  always_comb next_run = busy ? run + 13'h1 : 13'h0;
  always_ff @(posedge i_clock) run <= i_rst ? 13'h0 : next_run;
  chk_wr_one_pulse: assert property (wr |=> !wr) else $error("wr held");
  chk_rd_one_pulse: assert property (rd |=> !rd) else $error("rd held");
  chk_wr_when_idle: assert property (wr |-> !busy) else $error("wr while busy");
  chk_busy_after_wr: assert property (wr |=> busy[*8]) else $error("no busy");
  chk_busy_bound: assert property (run < 13'hFA2) else $error("busy too long");
  chk_strobe_excl: assert property (!(wr && rd)) else $error("wr with rd");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
  chk_reset_quiet: assert property ($fell(i_rst) |-> !busy && rdata == 4'h0)
    else $error("bus not quiet");
endmodule

// >>> tb.sv
/* Bench joining host and recorder ends of the nibble port.
   Assumes the shortened pointer busy and sample times set below. */
`timescale 1ns/100ps
module tb;
  import recorder_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_power_down = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [3:0] i_cmd = 4'h0;
  logic [ADDR_W-1:0] i_arg = '0;
  logic [3:0] i_rec_sample = 4'h0;
  logic i_play_ready = 1'b0;
  logic i_play_valid = 1'b0;
  logic [3:0] i_play_data = 4'h0;
  logic o_cmd_ready, o_probe_dac, o_recording, o_playing;
  logic [ADDR_W-1:0] dev_ptr, host_ptr, addr;
  logic [3:0] o_gain;
  logic [ARG_W-1:0] o_phrase, o_length;
  route_t o_feed_route, o_speaker_route;
  logic [31:0] o_record_seconds;
  logic gain_go;
  int gain_pulses = 0;
  int errors = 0;
  int num_checks = 0;
  recorder_bus_if bus ();
  recorder_device #(.SET_POINTER_BUSY(20), .ADDR_BUSY(10), .SAMPLE_PERIOD(6000),
    .TICK_HIGH(4500)) i_recorder_device (
    .i_clock(i_clock), .i_rst(i_rst), .bus(bus), .i_power_down(i_power_down),
    .o_probe_dac(o_probe_dac), .o_feed_route(o_feed_route),
    .o_speaker_route(o_speaker_route), .i_rec_sample(i_rec_sample), .o_play_valid(),
    .o_play_data(), .i_play_ready(i_play_ready), .o_gain(o_gain), .o_gain_start(gain_go),
    .o_phrase(o_phrase), .o_length(o_length), .o_pointer(dev_ptr),
    .o_recording(o_recording), .o_playing(o_playing), .o_record_seconds(o_record_seconds));
  recorder_host i_recorder_host (
    .i_clock(i_clock), .i_rst(i_rst), .bus(bus), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_arg(i_arg), .o_cmd_ready(o_cmd_ready), .o_pointer(host_ptr),
    .o_pointer_valid(), .i_play_valid(i_play_valid), .i_play_data(i_play_data),
    .o_play_ready(), .o_rec_data(), .o_rec_valid());
  recorder_bus_props i_recorder_bus_props (.i_clock(i_clock), .i_rst(i_rst),
    .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .busy(bus.busy));
  always #2 i_clock = ~i_clock;
  // Random samples and a stalling drain side
  always @(posedge i_clock)
  begin
    i_play_ready <= 1'($urandom);
    i_play_valid <= 1'($urandom);
    i_play_data <= 4'($urandom);
    i_rec_sample <= 4'($urandom);
  end
  // One start pulse per completed gain command
  always @(posedge i_clock)
    if (gain_go === 1'b1)
      gain_pulses++;
  function automatic logic [31:0] secs(input int kb, input int hz, input int b);
    return 32'((1024 * (kb - 64)) / (hz * b));
  endfunction
  task check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Issue one command, then wait until the port is idle again
  task cmd(input logic [3:0] c, input logic [ADDR_W-1:0] a);
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    i_cmd <= c;
    i_arg <= a;
    i_cmd_valid <= 1'b1;
    do @(posedge i_clock); while (o_cmd_ready !== 1'b1 && ++n < 30000);
    i_cmd_valid <= 1'b0;
    repeat (3) @(posedge i_clock);
    // Busy low for 8 cycles running only happens once the host is idle
    do
    begin
      @(posedge i_clock);
      quiet = (bus.busy === 1'b0) ? quiet + 1 : 0;
    end
    while (quiet < 8 && ++n < 30000);
    check(40'(n < 30000), 40'h1);
  endtask
  initial
  begin
    void'($urandom(74325));
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    check(40'(o_record_seconds), 40'(secs(32768, 8000, 4)));
    i_power_down <= 1'b1;
    repeat (2) @(posedge i_clock);
    check({o_feed_route, o_speaker_route}, {ROUTE_GND, ROUTE_GND});
    i_power_down <= 1'b0;
    cmd(CMD_IDLE, '0);
    cmd(CMD_PAUSE, '0);
    // Random pointer, then the all-ones corner
    for (int i = 0; i < 2; i++)
    begin
      addr = i ? {ADDR_W{1'b1}} : {8'($urandom), $urandom};
      cmd(CMD_SET_POINTER, addr);
      check(dev_ptr, addr);
      cmd(CMD_GET_POINTER, '0);
      check(host_ptr, addr);
    end
    addr = 40'($urandom);
    cmd(CMD_PHRASE_SELECT, addr);
    check(40'(o_phrase), 40'(addr[7:0]));
    cmd(CMD_LENGTH_SET, 40'hFF);
    check(40'(o_length), 40'hFF);
    cmd(CMD_OUTPUT_GAIN, addr);
    check(40'(o_gain), 40'(addr[3:0]));
    check(40'(gain_pulses), 40'h1);
    // Host-streamed record, then host-streamed playback
    cmd(CMD_RECORD, '0);
    cmd(CMD_HOST_STREAM, '0);
    cmd(CMD_START, '0);
    check({o_recording, o_probe_dac, o_feed_route, o_speaker_route},
      {1'b1, 1'b0, ROUTE_LPF, ROUTE_SG});
    cmd(CMD_STOP, '0);
    cmd(CMD_PLAY, '0);
    cmd(CMD_HOST_STREAM, '0);
    cmd(CMD_START, '0);
    check({o_playing, o_probe_dac, o_feed_route, o_speaker_route},
      {1'b1, 1'b1, ROUTE_LPF, ROUTE_LPF});
    cmd(CMD_STOP, '0);
    results;
  end
  // Watchdog roughly 19000 cycles beyond the expected run of about 81000
  initial
  begin
    repeat (100000) @(posedge i_clock);
    errors++;
    results;
  end
endmodule
